// >>> core/byte_capture.sv
// byte register with load enable, used for captured query fields
`timescale 1ns/1ns
module byte_capture #(
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic load,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else if (ce && load) begin
            q <= d;
        end
    end
endmodule : byte_capture

// >>> core/qp_pkg.sv
// constants for the protocol and registration query handler
package qp_pkg;
    localparam logic [7:0] PROTO_QUERY_CODE = 8'h08;
    localparam logic [7:0] PROTO_REPLY_CODE = 8'h09;
    localparam logic [7:0] REG_QUERY_CODE = 8'h10;
    localparam logic [7:0] RSVD_BYTE = 8'h00;
    localparam logic [7:0] FILL_BYTE = 8'h00;
    localparam int QUERY_LEN = 8;
    localparam int TAG_HI_POS = 2;
    localparam int TAG_LO_POS = 3;
    localparam int PATH_POS = 4;
    localparam int LIST_POS = 4;
    localparam int LIST_LEN = 11;
    localparam int REPLY_LEN = LIST_POS + LIST_LEN;
    localparam int VU_ENTRY_LEN = 5;
    localparam int RECORD_LEN = 18;
    localparam int RECORDS_PER_FRAME = 8;
    localparam int OFFSET_ZERO = 0;
endpackage : qp_pkg

// >>> core/query_handler.sv
// protocol query reply and registration query table upload engine
// Operation
// - reply leaves on the query's own port
// - reply code 09h, reserved, then tag
// - reply tag copies query tag exactly
// - eleven byte list at four, zero filled
// - standard protocol is one code byte
// - vendor entry is code plus four identifier
// - listed protocol codes are all distinct
// - registration query code 10h carries return path
// - return path placed in reply and ready; here it is only put out on ready_path, no tx byte carries it
// - data-ready gives total size, offset zero
// - eighteen byte records, eight per frame
`timescale 1ns/1ns
module query_handler
    import qp_pkg::*;
#(
    parameter int PORT_W = 2,
    parameter int ENTRY_W = 6,
    parameter logic [LIST_LEN*8-1:0] PROTO_LIST = {8'h01, {10{8'h00}}}
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic rx_valid,
    input wire logic rx_first,
    input wire logic [7:0] rx_data,
    input wire logic [PORT_W-1:0] rx_port,
    input wire logic [ENTRY_W-1:0] table_entries,
    input wire logic data_reply_seen,
    output logic [ENTRY_W-1:0] rec_index,
    input wire logic [RECORD_LEN*8-1:0] rec_data,
    input wire logic tx_ready,
    output logic tx_valid,
    output logic tx_first,
    output logic tx_last,
    output logic [7:0] tx_data,
    output logic [PORT_W-1:0] tx_port,
    output logic ready_valid,
    output logic [31:0] ready_path,
    output logic [15:0] ready_tag,
    output logic [31:0] ready_count,
    output logic [31:0] ready_offset,
    output logic data_frame_start,
    output logic busy
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_RX = 5'b00010,
        ST_REPLY = 5'b00100,
        ST_WAIT = 5'b01000,
        ST_DATA = 5'b10000
    } state_e;

    state_e state;
    state_e next_state;
    logic [3:0] rx_cnt;
    logic [7:0] qcode;
    logic [4:0] tx_cnt;
    logic [4:0] rec_byte;
    logic [3:0] frame_rec;
    logic [PORT_W-1:0] q_port;
    logic [15:0] q_tag;
    logic [31:0] q_path;
    logic [7:0] reply_byte;
    logic [7:0] rec_byte_val;

    wire in_idle = state == ST_IDLE;
    wire in_rx = state == ST_RX;
    wire in_reply = state == ST_REPLY;
    wire in_data = state == ST_DATA;

    wire rx_take = ce && rx_valid;
    wire rx_byte = rx_take && in_rx;
    wire start_query = rx_take && rx_first && in_idle;
    wire rx_done = rx_byte && rx_cnt == 4'(QUERY_LEN - 1);
    wire is_proto = qcode == PROTO_QUERY_CODE;
    wire is_reg = qcode == REG_QUERY_CODE;
    wire tx_fire = ce && tx_valid && tx_ready;
    wire reply_end = tx_cnt == 5'(REPLY_LEN - 1);
    wire rec_end = rec_byte == 5'(RECORD_LEN - 1);
    wire last_rec = rec_index == table_entries - 1'b1;
    wire frame_full = frame_rec == 4'(RECORDS_PER_FRAME - 1);
    wire state_change = ce && state != next_state;
    wire rec_done = tx_fire && in_data && rec_end;
    wire data_first = rec_byte == '0 && frame_rec == '0;
    wire data_last = rec_end && (frame_full || last_rec);
    wire tag_hi_load = rx_byte && rx_cnt == 4'(TAG_HI_POS);
    wire tag_lo_load = rx_byte && rx_cnt == 4'(TAG_LO_POS);
    wire reply_arrived = ce && data_reply_seen;
    wire reg_done = rx_done && is_reg;
    wire [31:0] path_now = {q_path[31:8], rx_data};
    wire [31:0] total_bytes = 32'(table_entries) * 32'(RECORD_LEN);
    wire [4:0] list_pos = tx_cnt - 5'(LIST_POS);
    wire [7:0] list_byte = PROTO_LIST[8*(LIST_LEN-1-list_pos)+:8];

    // tag bytes captured field by field
    byte_capture #(.WIDTH(8)) tag_hi (
        .clock(clock), .sys_rst(sys_rst), .ce(ce),
        .load(tag_hi_load),
        .d(rx_data), .q(q_tag[15:8])
    );
    byte_capture #(.WIDTH(8)) tag_lo (
        .clock(clock), .sys_rst(sys_rst), .ce(ce),
        .load(tag_lo_load),
        .d(rx_data), .q(q_tag[7:0])
    );
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_path
            // return path bytes four to seven
            byte_capture #(.WIDTH(8)) path_b (
                .clock(clock), .sys_rst(sys_rst), .ce(ce),
                .load(rx_take && state == ST_RX
                    && rx_cnt == 4'(PATH_POS + gi)),
                .d(rx_data), .q(q_path[31-8*gi -: 8])
            );
        end
    endgenerate

    // code, reserved and tag at fixed bytes
    always_comb begin
        case (tx_cnt)
            5'd0: reply_byte = PROTO_REPLY_CODE;
            5'd1: reply_byte = RSVD_BYTE;
            5'd2: reply_byte = q_tag[15:8];
            5'd3: reply_byte = q_tag[7:0];
            default: reply_byte = list_byte;
        endcase
    end

    // record bytes sent most significant first
    assign rec_byte_val = rec_data[8*(RECORD_LEN-1-rec_byte)+:8];

    assign tx_valid = in_reply || in_data;
    assign busy = !in_idle;

    // next state from the received code
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start_query) begin
                    next_state = ST_RX;
                end
            end
            ST_RX: begin
                if (rx_done && is_reg) begin
                    next_state = ST_WAIT;
                end else if (rx_done && is_proto) begin
                    next_state = ST_REPLY;
                end else if (rx_done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_REPLY: begin
                if (tx_fire && reply_end) begin
                    next_state = ST_IDLE;
                end
            end
            ST_WAIT: begin
                if (reply_arrived && table_entries == '0) begin
                    next_state = ST_IDLE;
                end else if (reply_arrived) begin
                    next_state = ST_DATA;
                end
            end
            ST_DATA: begin
                if (rec_done && last_rec) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // state register, frozen while ce is low
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // query code and receiving port
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            qcode <= '0;
            q_port <= '0;
        end else if (start_query) begin
            qcode <= rx_data;
            q_port <= rx_port;
        end
    end

    // byte position within the query
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rx_cnt <= '0;
        end else if (start_query) begin
            rx_cnt <= 4'd1;
        end else if (rx_byte) begin
            rx_cnt <= rx_cnt + 4'd1;
        end
    end

    // reply byte counter
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tx_cnt <= '0;
        end else if (state_change) begin
            tx_cnt <= '0;
        end else if (tx_fire && in_reply) begin
            tx_cnt <= tx_cnt + 5'd1;
        end
    end

    // byte within the current record
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rec_byte <= '0;
        end else if (state_change) begin
            rec_byte <= '0;
        end else if (tx_fire && in_data) begin
            rec_byte <= rec_end ? 5'd0 : rec_byte + 5'd1;
        end
    end

    // record being sent
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rec_index <= '0;
        end else if (state_change) begin
            rec_index <= '0;
        end else if (rec_done) begin
            rec_index <= rec_index + 1'b1;
        end
    end

    // at most eight records a frame
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            frame_rec <= '0;
        end else if (state_change) begin
            frame_rec <= '0;
        end else if (rec_done) begin
            frame_rec <= frame_full ? 4'd0 : frame_rec + 4'd1;
        end
    end

    // reply leaves by the query port
    assign tx_port = q_port;
    assign tx_data = in_data ? rec_byte_val : reply_byte;
    assign tx_first = in_reply ? tx_cnt == '0 : data_first;
    assign tx_last = in_reply ? reply_end : data_last;
    assign data_frame_start = in_data && data_first;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ready_valid <= 1'b0;
        end else if (ce) begin
            ready_valid <= reg_done;
        end
    end

    // return path, last byte taken as it arrives
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ready_path <= '0;
        end else if (reg_done) begin
            ready_path <= path_now;
        end
    end

    // tag carried into the data-ready frame
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ready_tag <= '0;
        end else if (reg_done) begin
            ready_tag <= q_tag;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ready_count <= '0;
            ready_offset <= '0;
        end else if (reg_done) begin
            ready_count <= total_bytes;
            ready_offset <= 32'(OFFSET_ZERO);
        end
    end
endmodule : query_handler

// >>> tb/qh_far_end.sv
// far end model: stalling sink, data-reply answer, record store
`timescale 1ns/1ns
module qh_far_end
    import qp_pkg::*;
(
    input wire logic clock,
    input wire logic slow,
    input wire logic ready_valid,
    input wire logic [5:0] rec_index,
    output logic tx_ready,
    output logic data_reply_seen,
    output logic [RECORD_LEN*8-1:0] rec_data
);
    int wait_n = 0;
    always_comb begin
        for (int k = 0; k < RECORD_LEN; k++) begin
            rec_data[8*(RECORD_LEN-1-k) +: 8] = 8'(rec_index + k);
        end
    end
    initial tx_ready = 1'b0;
    initial data_reply_seen = 1'b0;
    always @(posedge clock) begin
        tx_ready <= #5 slow ? 1'($urandom_range(1)) : 1'b1;
        data_reply_seen <= #5 (wait_n == 1);
        wait_n <= ready_valid ? 2 + $urandom_range(6) : wait_n - (wait_n > 0);
    end
endmodule : qh_far_end

// >>> tb/qh_sva.sv
// assertion checker for the query handler
`timescale 1ns/1ns
module qh_sva
    import qp_pkg::*;
#(
    parameter int ENTRY_W = 6,
    parameter int PORT_W = 2
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic tx_ready,
    input wire logic tx_valid,
    input wire logic tx_first,
    input wire logic tx_last,
    input wire logic [7:0] tx_data,
    input wire logic [PORT_W-1:0] tx_port,
    input wire logic ready_valid,
    input wire logic [31:0] ready_count,
    input wire logic [ENTRY_W-1:0] table_entries,
    input wire logic data_frame_start
);
    logic [7:0] cnt;
    logic is_data;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= 8'h00;
            is_data <= 1'b0;
        end else if (tx_valid && tx_ready && ce) begin
            cnt <= tx_last ? 8'h00 : cnt + 8'h01;
            is_data <= tx_first ? data_frame_start : is_data;
        end
    end
    sequence s_wait;
        tx_valid && !(tx_ready && ce);
    endsequence
    property p_hold;
        s_wait |=> tx_valid && $stable(tx_data) && $stable(tx_port);
    endproperty
    a_hold: assert property (p_hold) else $error("moved in stall");
    property p_code;
        tx_valid && tx_first && !data_frame_start |->
            tx_data == PROTO_REPLY_CODE;
    endproperty
    a_code: assert property (p_code) else $error("bad code");
    property p_rsvd;
        tx_valid && !is_data && cnt == 1 |-> tx_data == RSVD_BYTE;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("bad byte 1");
    property p_rlen;
        tx_valid && tx_last && !is_data |-> cnt == REPLY_LEN - 1;
    endproperty
    a_rlen: assert property (p_rlen) else $error("reply length");
    property p_dlen;
        tx_valid && tx_last && is_data |-> (cnt + 1) % RECORD_LEN == 0;
    endproperty
    a_dlen: assert property (p_dlen) else $error("part record");
    property p_dmax;
        tx_valid && is_data |-> cnt < RECORD_LEN * RECORDS_PER_FRAME;
    endproperty
    a_dmax: assert property (p_dmax) else $error("frame too long");
    property p_count;
        ready_valid |-> ready_count == table_entries * RECORD_LEN;
    endproperty
    a_count: assert property (p_count) else $error("bad count");
    property p_pulse;
        ready_valid && ce |=> !ready_valid;
    endproperty
    a_pulse: assert property (p_pulse) else $error("long pulse");
    property p_port;
        tx_valid && !tx_first |-> $stable(tx_port);
    endproperty
    a_port: assert property (p_port) else $error("port moved");
endmodule : qh_sva
bind query_handler qh_sva #(.ENTRY_W(ENTRY_W), .PORT_W(PORT_W)) qh_sva_i (.*);

// >>> tb/query_handler_tb_top.sv
// testbench for the query handler
`timescale 1ns/1ns
module query_handler_tb_top
    import qp_pkg::*;
;
    // vendor identifier bytes are arbitrary
    localparam logic [87:0] LIST = 88'h0102_5a3c_017e_0000_0000_00;
    localparam int FR = RECORD_LEN * RECORDS_PER_FRAME;
    logic clock = 1'b0, sys_rst = 1'b1, ce = 1'b1, slow = 1'b0, cej = 1'b0;
    logic rx_valid = 1'b0, rx_first = 1'b0;
    logic [7:0] rx_data = '0, tx_data;
    logic [1:0] rx_port = '0, tx_port;
    logic [5:0] table_entries = '0, rec_index;
    logic data_reply_seen, tx_ready, tx_valid, tx_first, tx_last;
    logic ready_valid, data_frame_start, busy;
    logic [143:0] rec_data;
    logic [31:0] ready_path, ready_count, ready_offset;
    logic [15:0] ready_tag;
    int err_total = 0, checks_done = 0;
    int cnts[5] = '{0, 1, 8, 9, 17};
    query_handler #(.PROTO_LIST(LIST)) query_handler_i (.*);
    qh_far_end qh_far_end_i (.*);
    always #25 clock = ~clock;
    always @(posedge clock) ce <= #5 cej ? $urandom_range(3) != 0 : 1'b1;
    task automatic results;
        $display("checks %0d bad %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic send(logic [7:0] c, logic [15:0] t, logic [31:0] p,
                        logic [1:0] port);
        logic [63:0] f;
        f = {c, RSVD_BYTE, t, p};
        for (int i = 0; i < QUERY_LEN; i++) begin
            rx_valid = 1'b1;
            rx_first = (i == 0);
            rx_data = f[63-8*i -: 8];
            rx_port = port;
            @(posedge clock);
            #5;
        end
        rx_valid = 1'b0;
        rx_first = 1'b0;
    endtask : send
    task automatic beat(output logic [7:0] d, output logic [2:0] fls);
        int k;
        for (k = 0; k < 400; k++) begin
            @(negedge clock);
            if (tx_valid === 1'b1 && tx_ready === 1'b1 && ce === 1'b1) break;
        end
        if (k == 400) begin
            chk(0, 1);
            results();
        end
        d = tx_data;
        fls = {tx_first, tx_last, data_frame_start};
        @(posedge clock);
        #5;
    endtask : beat
    task automatic idle(int t);
        cej = 1'b0;
        repeat (12) @(posedge clock);
        #5;
        chk(busy, 0);
        chk(tx_valid, 0);
        $display("test %0d done", t);
    endtask : idle
    function automatic logic [7:0] exp_rep(int i, logic [15:0] tag);
        logic [127:0] r;
        r = {PROTO_REPLY_CODE, RSVD_BYTE, tag, LIST, FILL_BYTE};
        return r[127-8*i -: 8];
    endfunction : exp_rep
    initial begin
        logic [7:0] d;
        logic [2:0] s;
        logic [15:0] tg;
        logic [31:0] pa;
        int n;
        void'($urandom(85));
        cnts[4] = $urandom_range(63, 10);
        repeat (3) @(posedge clock);
        #5 sys_rst = 1'b0;
        for (int p = 0; p < 4; p++) begin
            tg = 16'($urandom);
            send(PROTO_QUERY_CODE, tg, $urandom, 2'(p));
            {slow, cej} = 2'(p);
            chk(tx_port, p);
            for (int i = 0; i < REPLY_LEN; i++) begin
                beat(d, s);
                chk(d, exp_rep(i, tg));
                chk(s, {i == 0, i == REPLY_LEN - 1, 1'b0});
            end
            idle(p);
        end
        send(8'h0a, 16'h1234, '0, 2'h1);
        chk(busy, 0);
        chk(ready_valid, 0);
        idle(4);
        foreach (cnts[j]) begin
            n = cnts[j];
            table_entries = 6'(n);
            // one tag outstanding at a time
            tg = 16'($urandom);
            pa = $urandom;
            slow = j[0];
            send(REG_QUERY_CODE, tg, pa, 2'(j));
            chk(ready_valid, 1);
            chk(ready_path, pa);
            chk(ready_tag, tg);
            chk(ready_count, n * RECORD_LEN);
            chk(ready_offset, OFFSET_ZERO);
            for (int b = 0; b < n * RECORD_LEN; b++) begin
                beat(d, s);
                chk(d, 8'(b / RECORD_LEN + b % RECORD_LEN));
                chk(s, {b % FR == 0, b % FR == FR - 1 ||
                    b == n * RECORD_LEN - 1, b % FR == 0});
            end
            idle(5 + j);
        end
        results();
    end
endmodule : query_handler_tb_top
